// ==== rtcsp_fifo.sv ====
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module rtcsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;

   assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = mem[rd_ptr[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule : rtcsp_fifo

// ==== rtcsp_master.sv ====
/*
 Behavioural bus master: clock, START, STOP and bit transfers.
 Assumes a pulled-up data wire; one bit takes 20 clk (160 ns).
*/
`timescale 1ns/1ps
module rtcsp_master (
   // Clock and wire level
   input wire logic clk,
   input wire logic sda,
   // Master drive
   output logic scl,
   output logic sda_low
);
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   // Data moves mid-low, held through the whole high phase
   task automatic bit_io(input logic b, output logic s);
      sda_low = !b;
      tick(5);
      scl = 1'b1;
      tick(5);
      s = sda;
      tick(5);
      scl = 1'b0;
      tick(5);
   endtask : bit_io
   task automatic start();
      sda_low = 1'b0;
      tick(5);
      scl = 1'b1;
      tick(5);
      sda_low = 1'b1;
      tick(5);
      scl = 1'b0;
      tick(5);
   endtask : start
   task automatic stop();
      sda_low = 1'b1;
      tick(5);
      scl = 1'b1;
      tick(5);
      sda_low = 1'b0;
      tick(10);
   endtask : stop
   task automatic xfer(input logic [7:0] d, input logic a,
      output logic [7:0] q, output logic r);
      logic b;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], b);
         q[i] = b;
      end
      bit_io(a, r);
   endtask : xfer
endmodule : rtcsp_master

// ==== rtcsp_pkg.sv ====
/*
 Package of the two-wire slave register port: address, widths, states.
 Assumes nothing of its surroundings.
*/
package rtcsp_pkg;
   localparam logic [6:0] SLAVE_ADDR = 7'h68;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam int PTR_W = 8;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int SYNC_STAGES = 2;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   // Fastest supported bus clock and sample clock rate
   localparam int FAST_MODE_KHZ = 400;
   localparam int CLK_MHZ = 125;
   localparam int SCL_HALF_CYCLES = (CLK_MHZ * 1000) / (FAST_MODE_KHZ * 2);

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR_ACK = 3'b010,
      ST_RX = 3'b011,
      ST_RX_ACK = 3'b100,
      ST_TX = 3'b101,
      ST_TX_ACK = 3'b110
   } rtcsp_state_t;
endpackage : rtcsp_pkg

// ==== rtcsp_port.sv ====
/*
 Two-wire serial slave port with auto-incrementing register pointer.
 Written bytes go out through a FIFO; read bytes come from the core
 by a combinational pointer lookup. The bus master makes all clocks.
*/
`timescale 1ns/1ps
// Functional notes
// - Acknowledge every byte received while addressed: address, pointer, data. The code does not acknowledge a data byte that arrives while the FIFO is full.
// - Acknowledger holds data line low through the whole ninth high phase.
// - After a not-acknowledged read byte, release the data line.
// - Keep sending read bytes until a not-acknowledge is sampled.
// - First byte after START is 7-bit address plus direction bit.
// - Address 1101000 with direction 0 selects receive mode.
// - Address 1101000 with direction 1 selects transmit mode.
// - First byte after write address loads the register pointer.
// - Any number of data bytes follow; each is stored and acknowledged. The code drops and does not ack a byte arriving while the FIFO is full.
// - Pointer advances by one after each data byte written or read.
// - Reads start at the register the pointer selects.
// - Without a new pointer, reads continue from the previous pointer.
// - STOP or repeated START ends a transfer; repeated START re-addresses.
// - START is data falling while clock high; STOP is data rising.
// - Data changes only while clock is low.
// - Standard and fast-mode bus rates are supported.
// - Below power-fail threshold, no register access takes place.
module rtcsp_port #(
   parameter int DEPTH = rtcsp_pkg::FIFO_DEPTH
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Serial bus; clock is input only
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // Supply monitor
   input wire logic POWER_FAIL,
   // Written bytes toward the core
   output logic WR_VALID,
   input wire logic WR_READY,
   output logic [rtcsp_pkg::PTR_W-1:0] WR_ADDR,
   output logic [rtcsp_pkg::DATA_W-1:0] WR_DATA,
   // Read lookup from the core
   output logic [rtcsp_pkg::PTR_W-1:0] RD_ADDR,
   input wire logic [rtcsp_pkg::DATA_W-1:0] RD_DATA,
   // Status
   output logic BUSY
);
   localparam int FW = rtcsp_pkg::PTR_W + rtcsp_pkg::DATA_W;

   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic scl_d;
   logic sda_d;
   logic pf_meta;
   logic pf;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   rtcsp_pkg::rtcsp_state_t state;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic first_rx;
   logic [rtcsp_pkg::PTR_W-1:0] ptr;
   logic [7:0] tx_byte;
   logic push;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [FW-1:0] fifo_out;
   logic full_hold;
   logic ack_drive;

   // Two stages before any logic reads the pins; idle bus is high
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_sync <= {scl_sync[0], SCL_IN};
         sda_sync <= {sda_sync[0], SDA_IN};
         scl_d <= scl_sync[1];
         sda_d <= sda_sync[1];
      end
   end

   // Supply flag from the monitor, also two stages
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         pf_meta <= 1'b0;
         pf <= 1'b0;
      end
      else
      begin
         pf_meta <= POWER_FAIL;
         pf <= pf_meta;
      end
   end

   // 125 MHz sampling gives many samples per fast-mode half period
   assign scl_rise = scl_sync[1] && !scl_d;
   assign scl_fall = !scl_sync[1] && scl_d;
   assign start_cond = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
   assign stop_cond = scl_sync[1] && scl_d && !sda_d && sda_sync[1];

   // Bus state; bits sampled only on clock rise, so data is stable high
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         state <= rtcsp_pkg::ST_IDLE;
         bit_cnt <= rtcsp_pkg::BIT_ZERO;
         shreg <= 8'h00;
         first_rx <= 1'b0;
      end
      else if (start_cond)
      begin
         state <= rtcsp_pkg::ST_ADDR;
         // Clock fall that closes START wraps this to zero
         bit_cnt <= rtcsp_pkg::BIT_ZERO - 4'h1;
      end
      else if (stop_cond)
      begin
         state <= rtcsp_pkg::ST_IDLE;
      end
      else
      begin
         unique case (state)
            rtcsp_pkg::ST_IDLE:
            begin
               bit_cnt <= rtcsp_pkg::BIT_ZERO;
            end
            rtcsp_pkg::ST_ADDR, rtcsp_pkg::ST_RX:
            begin
               if (scl_rise)
               begin
                  shreg <= {shreg[6:0], sda_sync[1]};
               end
               if (scl_fall)
               begin
                  if (bit_cnt == rtcsp_pkg::BIT_LAST)
                  begin
                     bit_cnt <= rtcsp_pkg::BIT_ZERO;
                     if (state == rtcsp_pkg::ST_RX)
                     begin
                        state <= rtcsp_pkg::ST_RX_ACK;
                     end
                     else if (shreg[7:1] == rtcsp_pkg::SLAVE_ADDR && !pf)
                     begin
                        state <= rtcsp_pkg::ST_ADDR_ACK;
                     end
                     else
                     begin
                        state <= rtcsp_pkg::ST_IDLE;
                     end
                  end
                  else
                  begin
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            rtcsp_pkg::ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  first_rx <= 1'b1;
                  // Direction bit picks receive or transmit mode
                  state <= shreg[0] ? rtcsp_pkg::ST_TX
                                    : rtcsp_pkg::ST_RX;
               end
            end
            rtcsp_pkg::ST_RX_ACK:
            begin
               if (scl_fall)
               begin
                  first_rx <= 1'b0;
                  state <= rtcsp_pkg::ST_RX;
               end
            end
            rtcsp_pkg::ST_TX:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt == rtcsp_pkg::BIT_LAST)
                  begin
                     bit_cnt <= rtcsp_pkg::BIT_ZERO;
                     state <= rtcsp_pkg::ST_TX_ACK;
                  end
                  else
                  begin
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            rtcsp_pkg::ST_TX_ACK:
            begin
               // Answer taken at rise, acted on at fall, so the
               // acknowledge fall is not counted as a data bit
               if (scl_rise)
               begin
                  shreg <= {shreg[6:0], sda_sync[1]};
               end
               if (scl_fall)
               begin
                  // Not-acknowledge ends the read; released until START
                  state <= shreg[0] ? rtcsp_pkg::ST_IDLE
                                    : rtcsp_pkg::ST_TX;
               end
            end
            default:
            begin
               state <= rtcsp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Pointer: loaded by first write byte, bumped per data byte
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         ptr <= rtcsp_pkg::PTR_RESET;
      end
      else if (state == rtcsp_pkg::ST_RX_ACK && scl_fall && !pf)
      begin
         if (first_rx)
         begin
            ptr <= shreg;
         end
         else
         begin
            ptr <= ptr + 8'h01;
         end
      end
      else if (state == rtcsp_pkg::ST_TX_ACK && scl_rise)
      begin
         // Early bump: next byte is fetched before the fall
         ptr <= ptr + 8'h01;
      end
   end

   // Read byte fetched at pointer; pointer persists across transfers
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         tx_byte <= 8'h00;
      end
      else if (state == rtcsp_pkg::ST_TX && scl_fall)
      begin
         tx_byte <= {tx_byte[6:0], 1'b0};
      end
      else if (state != rtcsp_pkg::ST_TX)
      begin
         tx_byte <= pf ? 8'hff : RD_DATA;
      end
   end

   // Full FIFO: byte dropped and its acknowledge withheld
   assign push = state == rtcsp_pkg::ST_RX && scl_fall &&
                 bit_cnt == rtcsp_pkg::BIT_LAST && !first_rx && !pf;
   assign ack_drive = state == rtcsp_pkg::ST_ADDR_ACK ||
                      (state == rtcsp_pkg::ST_RX_ACK && !full_hold);

   // Decided as the byte ends, so the byte filling the last slot is acked
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         full_hold <= 1'b0;
      end
      else if (state == rtcsp_pkg::ST_RX && scl_fall &&
               bit_cnt == rtcsp_pkg::BIT_LAST)
      begin
         full_hold <= pf || (!first_rx && !fifo_in_ready);
      end
   end

   rtcsp_fifo #(
      .WIDTH(FW),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(CLK),
      .rstn(RSTN),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data({ptr, shreg}),
      .out_valid(fifo_out_valid),
      .out_ready(WR_READY && !(WR_VALID && !WR_READY)),
      .out_data(fifo_out)
   );

   // Registered write stream; reloads every cycle, pops a word while WR_READY is high and shows it with WR_VALID the next cycle
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         WR_VALID <= 1'b0;
         WR_ADDR <= rtcsp_pkg::PTR_RESET;
         WR_DATA <= 8'h00;
      end
      else
      begin
         WR_VALID <= fifo_out_valid && WR_READY;
         WR_ADDR <= fifo_out[FW-1 -: rtcsp_pkg::PTR_W];
         WR_DATA <= fifo_out[rtcsp_pkg::DATA_W-1:0];
      end
   end

   // Open-drain data: only ever pulls low; clock line never driven
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         SDA_OUT <= 1'b0;
         SDA_OE <= 1'b0;
         RD_ADDR <= rtcsp_pkg::PTR_RESET;
         BUSY <= 1'b0;
      end
      else
      begin
         SDA_OUT <= 1'b0;
         SDA_OE <= ack_drive || (state == rtcsp_pkg::ST_TX &&
                   !tx_byte[7]);
         RD_ADDR <= ptr;
         BUSY <= state != rtcsp_pkg::ST_IDLE;
      end
   end
endmodule : rtcsp_port

// ==== rtcsp_port_sva.sv ====
/*
 Pin-level assertions for the two-wire slave port.
 Assumes raw bus levels at SCL_IN and SDA_IN and a 125 MHz CLK.
*/
`timescale 1ns/1ps
module rtcsp_port_sva (
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Bus and status
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic POWER_FAIL,
   input wire logic WR_VALID,
   input wire logic WR_READY,
   input wire logic [rtcsp_pkg::PTR_W-1:0] RD_ADDR,
   input wire logic BUSY
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);

   sequence start_seen;
      SCL_IN && $past(SCL_IN) && $fell(SDA_IN);
   endsequence
   sequence stop_seen;
      SCL_IN && $past(SCL_IN) && $rose(SDA_IN);
   endsequence

   a_start_release: assert property (start_seen |-> !SDA_OE [*8])
      else $error("data line driven just after start");
   a_stop_idle: assert property (stop_seen |-> ##[1:12] !BUSY)
      else $error("busy stays after stop");
   a_ack_hold: assert property ($rose(SCL_IN) && SDA_OE |-> SDA_OE [*8])
      else $error("ack dropped in clock high phase");
   a_oe_stable: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE))
      else $error("data drive changed while clock high");
   a_pf_quiet: assert property (POWER_FAIL [*8] |-> !SDA_OE)
      else $error("bus answered under power fail");
   a_wr_ready: assert property (WR_VALID |-> $past(WR_READY))
      else $error("write strobe without ready");
   a_out_low: assert property (SDA_OUT == 1'b0)
      else $error("data output level not low");
   a_ptr_busy: assert property (!$stable(RD_ADDR) |-> BUSY || $past(BUSY))
      else $error("pointer moved outside a transfer");
endmodule : rtcsp_port_sva

bind rtcsp_port rtcsp_port_sva rtcsp_port_sva_i (.CLK(CLK), .RSTN(RSTN),
   .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
   .POWER_FAIL(POWER_FAIL), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
   .RD_ADDR(RD_ADDR), .BUSY(BUSY));

// ==== tb_top.sv ====
/*
 Self-checking bench of the slave port with a master model.
 Assumes the core answers RD_DATA as RD_ADDR xor a5.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
   logic clk = 1'b0, rstn = 1'b0, pf = 1'b0, wr_ready = 1'b1;
   logic scl, sda_low, sda, sda_out, sda_oe, wr_valid, busy, r;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data, q;
   logic [15:0] exp_q[$];
   logic [15:0] x;
   logic [31:0] seed = 32'hf1bf0eb8;
   int n_errors = 0, tests_run = 0, cyc = 0;
   assign sda = !(sda_oe || sda_low);
   assign rd_data = rd_addr ^ 8'ha5;
   always #4 clk = ~clk;
   rtcsp_port #(.DEPTH(16)) rtcsp_port_i (.CLK(clk), .RSTN(rstn),
      .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
      .POWER_FAIL(pf), .WR_VALID(wr_valid), .WR_READY(wr_ready),
      .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_ADDR(rd_addr),
      .RD_DATA(rd_data), .BUSY(busy));
   rtcsp_master rtcsp_master_i (.clk(clk), .sda(sda), .scl(scl),
      .sda_low(sda_low));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic conclude();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude
   // Write a byte, optionally after a START; e is the expected ack level
   task automatic wb(input logic [7:0] d, input logic e, input logic s);
      if (s)
         rtcsp_master_i.start();
      rtcsp_master_i.xfer(d, 1'b1, q, r);
      `CHK("ack", e, r)
   endtask : wb
   task automatic rd(input int n, input logic [7:0] p);
      wb(8'hd1, 1'b0, 1'b1);
      for (int k = 0; k < n; k++)
      begin
         rtcsp_master_i.xfer(8'hff, k == n - 1, q, r);
         `CHK("rd", 8'(p + k) ^ 8'ha5, q)
      end
      `CHK("release", 1'b1, sda)
      rtcsp_master_i.stop();
   endtask : rd
   always @(negedge clk)
      if (wr_valid === 1'b1)
      begin
         x = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hxxxx;
         `CHK("wr", x, {wr_addr, wr_data})
      end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         conclude();
      end
   end
   initial
   begin
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      // Stall the core so the FIFO fills; the 17th byte is refused
      wr_ready = 1'b0;
      wb(8'hd0, 1'b0, 1'b1);
      wb(8'hf8, 1'b0, 1'b0);
      for (int i = 0; i < 17; i++)
      begin
         seed = lfsr(seed);
         if (i < 16)
            exp_q.push_back({8'(8'hf8 + i), seed[7:0]});
         wb(seed[7:0], i == 16, 1'b0);
      end
      rtcsp_master_i.stop();
      repeat (80)
      begin
         seed = lfsr(seed);
         wr_ready = seed[0];
         @(negedge clk);
      end
      wr_ready = 1'b1;
      repeat (40) @(negedge clk);
      `CHK("drained", 0, exp_q.size())
      $display("test fifo done");
      wb(8'hd0, 1'b0, 1'b1);
      wb(8'h40, 1'b0, 1'b0);
      rtcsp_master_i.stop();
      rd(3, 8'h40);
      rd(2, 8'h43);
      $display("test read done");
      wb(8'hd0, 1'b0, 1'b1);
      wb(8'h10, 1'b0, 1'b0);
      rd(1, 8'h10);
      $display("test restart done");
      for (int j = 0; j < 2; j++)
      begin
         seed = lfsr(seed);
         wb({j == 0 ? 7'h69 : 7'h28, seed[0]}, 1'b1, 1'b1);
         wb(seed[15:8], 1'b1, 1'b0);
         rtcsp_master_i.stop();
      end
      $display("test mismatch done");
      pf = 1'b1;
      repeat (8) @(negedge clk);
      wb(8'hd0, 1'b1, 1'b1);
      wb(8'h00, 1'b1, 1'b0);
      wb(8'hd1, 1'b1, 1'b1);
      rtcsp_master_i.stop();
      pf = 1'b0;
      repeat (8) @(negedge clk);
      $display("test power fail done");
      conclude();
   end
endmodule : tb_top
